/* File: logic/isvl_cfg.svh */
`ifndef ISVL_CFG_SVH
`define ISVL_CFG_SVH

// ============================================================
// Vector numbers
`define ISVL_VEC_NMI       7'h07
`define ISVL_VEC_PIN0      7'h10
`define ISVL_VEC_XFER_DONE 7'h18
`define ISVL_VEC_WDOG0     7'h19
`define ISVL_VEC_WDOG1     7'h1a
`define ISVL_VEC_BREAK     7'h1b
`define ISVL_VEC_CONV      7'h1c
`define ISVL_VEC_FRT0      7'h30
`define ISVL_VEC_NONE      7'h00

// ============================================================
// Source slots in the request vector
`define ISVL_NSRC          16
`define ISVL_SRC_NMI       0
`define ISVL_SRC_PIN0      1
`define ISVL_SRC_XFER_DONE 4
`define ISVL_SRC_WDOG0     5
`define ISVL_SRC_WDOG1     6
`define ISVL_SRC_BREAK     7
`define ISVL_SRC_CONV      8
`define ISVL_SRC_FRT0      9
`define ISVL_NFRT          7

// ============================================================
// Priority level groups and sense encodings
`define ISVL_NGRP          8
`define ISVL_GRP_NONE      4'hf
`define ISVL_SENSE_LOW     2'h0
`define ISVL_SENSE_FALL    2'h1
`define ISVL_SENSE_RISE    2'h2
`define ISVL_SENSE_BOTH    2'h3

// ============================================================
// Reset values
`define ISVL_SENSE_RST     6'h00
`define ISVL_ENABLE_RST    3'h0
`define ISVL_LEVEL_RST     8'h00

`endif

/* File: logic/isvl_pkg.sv */
package isvl_pkg;
  typedef enum logic [1:0] {
    isvl_sense_low,
    isvl_sense_fall,
    isvl_sense_rise,
    isvl_sense_both
  } isvl_sense_t;
  typedef logic [6:0] isvl_vec_t;
  typedef logic [23:0] isvl_addr_t;
endpackage

/* File: logic/isvl_pin_detect.sv */
`timescale 1ns/1ps
`include "isvl_cfg.svh"
module isvl_pin_detect import isvl_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // Pin, already synchronised
  input  wire logic       pin_level,
  input  wire logic [1:0] sense,
  // Event out
  output logic            hit
);
  logic prev_q;
  wire  fell = prev_q & ~pin_level;
  wire  rose = ~prev_q & pin_level;

  // Low level asserts every cycle the pin sits low; edges assert once
  always_comb begin
    unique case (isvl_sense_t'(sense))
      isvl_sense_low:  hit = ~pin_level;
      isvl_sense_fall: hit = fell;
      isvl_sense_rise: hit = rose;
      isvl_sense_both: hit = fell | rose;
    endcase
  end

  // Reset to high so that a pin held low at release counts as a fall
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else if (clk_en) begin
      prev_q <= pin_level;
    end
  end
endmodule

/* File: logic/isvl_vector_map.sv */
`timescale 1ns/1ps
`include "isvl_cfg.svh"
module isvl_vector_map import isvl_pkg::*; (
  // Selection
  input  wire logic [3:0]  slot,
  input  wire logic        advanced_mode,
  // Result
  output isvl_vec_t        vec_num,
  output isvl_addr_t       vec_addr
);
  function automatic isvl_vec_t slot_to_vec(input logic [3:0] s);
    isvl_vec_t v;
    v = `ISVL_VEC_NONE;
    if (s == 4'(`ISVL_SRC_NMI)) v = `ISVL_VEC_NMI;
    else if (s < 4'(`ISVL_SRC_XFER_DONE)) v = `ISVL_VEC_PIN0 + 7'(s - 4'(`ISVL_SRC_PIN0));
    else if (s < 4'(`ISVL_SRC_FRT0)) v = `ISVL_VEC_XFER_DONE + 7'(s - 4'(`ISVL_SRC_XFER_DONE));
    else v = `ISVL_VEC_FRT0 + 7'(s - 4'(`ISVL_SRC_FRT0));
    return v;
  endfunction

  assign vec_num  = slot_to_vec(slot);
  assign vec_addr = advanced_mode ? {15'h0000, vec_num, 2'h0}
                                  : {16'h0000, vec_num, 1'h0};
endmodule

/* File: logic/isvl_top.sv */
// Notes on behaviour
// - Non-maskable request always wins, ignores masks
// - Non-maskable edge chosen by edge select bit
// - Non-maskable vector 7, addresses 000E/00001C
// - Pins sense low, fall, rise or both
// - Sense code 00 low, 01 fall, 10 rise, 11 both
// - Each pin request individually enabled
// - Pin flag shows request, software clears it
// - Clear needs read-as-one then write zero
// - Flags set regardless of enable
// - Pins map to vectors 16, 17, 18
// - Detection independent of pin direction
// - External inputs wake from software standby
// - Eleven peripheral sources plus address break
// - Peripheral request from own flag and enable
// - Software sets priority level per group
// - Transfer-controller requests ignore core masks
// - Default: address break first, then lowest vector number wins
// - Equal levels resolve by vector order
// - Transfer software-done at vector 24
// - Address break vector 27, no group
// - Conversion done at vector 28
// - Timer capture/compare/overflow vectors 48 to 54
`timescale 1ns/1ps
`include "isvl_cfg.svh"
module isvl_top import isvl_pkg::*; #(
  parameter int NPIN = 3
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // External pins (asynchronous); direction of the shared pin is irrelevant
  input  wire logic              nmi_pin,
  input  wire logic [NPIN-1:0]   external_request_pins,
  // System control
  input  wire logic              nonmaskable_edge_select,
  input  wire logic              advanced_mode,
  input  wire logic              software_standby,
  // Pin request control
  input  wire logic [2*NPIN-1:0] pin_sense_control_regs,
  input  wire logic              sense_wr,
  input  wire logic [NPIN-1:0]   pin_request_enable_reg,
  input  wire logic              status_rd,
  input  wire logic              status_wr,
  input  wire logic [NPIN-1:0]   status_wdata,
  // Priority level groups, one bit each: pins 0-2, xfer, wdog0, wdog1, conv, frt
  input  wire logic [7:0]        priority_level_regs,
  // Peripheral requests, each already flag and enable of its module
  input  wire logic              transfer_sw_done_request,
  input  wire logic              watchdog0_interval_request,
  input  wire logic              watchdog1_interval_request,
  input  wire logic              address_break_request,
  input  wire logic              conversion_done_request,
  input  wire logic [6:0]        freerun_timer_requests,
  input  wire logic              transfer_route,
  // Core side
  input  wire logic              nmi_ack,
  input  wire logic              pin_ack,
  input  wire logic [1:0]        pin_ack_index,
  output logic [NPIN-1:0]        pin_request_status_reg,
  output logic [NPIN-1:0]        pin_sense_q,
  output logic                   irq_valid_q,
  output logic                   irq_nonmaskable_q,
  output logic                   irq_to_transfer_q,
  output isvl_vec_t              irq_vector_q,
  output isvl_addr_t             irq_address_q,
  output logic                   wake_q
);
  // ============================================================
  // Pin synchronisers
  logic [NPIN:0] sync1_q;
  logic [NPIN:0] sync2_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else if (clk_en) begin
      sync1_q <= {nmi_pin, external_request_pins};
      sync2_q <= sync1_q;
    end
  end

  // ============================================================
  // Non-maskable edge
  logic nmi_prev_q;
  logic nmi_pend_q;
  wire  nmi_lvl  = sync2_q[NPIN];
  wire  nmi_edge = nonmaskable_edge_select ? (nmi_lvl & ~nmi_prev_q)
                                           : (~nmi_lvl & nmi_prev_q);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else if (clk_en) begin
      nmi_prev_q <= nmi_lvl;
      nmi_pend_q <= nmi_edge | (nmi_pend_q & ~nmi_ack);
    end
  end

  // ============================================================
  // Pin request flags
  logic [2*NPIN-1:0] sense_q;
  logic [NPIN-1:0]   flag_q;
  logic [NPIN-1:0]   read_one_q;
  logic [NPIN-1:0]   hit;
  logic [NPIN-1:0]   flag_d;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sense_q <= `ISVL_SENSE_RST;
    end else if (clk_en && sense_wr) begin
      sense_q <= pin_sense_control_regs;
    end
  end

  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    isvl_pin_detect u_det (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .pin_level (sync2_q[i]),
      .sense     (sense_q[2*i+1:2*i]),
      .hit       (hit[i])
    );
    wire is_level = (sense_q[2*i+1:2*i] == `ISVL_SENSE_LOW);
    wire clr_sw   = status_wr & ~status_wdata[i] & read_one_q[i];
    // Exception handling clears edge flags; level flags only once the pin is high
    wire clr_ack  = pin_ack & (pin_ack_index == 2'(i)) & (~is_level | sync2_q[i]);
    assign flag_d[i] = hit[i] | (flag_q[i] & ~clr_sw & ~clr_ack);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_q     <= '0;
      read_one_q <= '0;
    end else if (clk_en) begin
      flag_q     <= flag_d;
      // A write consumes the read; a fresh read re-arms it
      read_one_q <= status_rd ? flag_q : (status_wr ? '0 : read_one_q);
    end
  end

  // ============================================================
  // Source requests and arbitration
  logic [`ISVL_NSRC-1:0] req;
  logic [`ISVL_NSRC-1:0] hi_lvl;
  assign req = {freerun_timer_requests, conversion_done_request, address_break_request,
                watchdog1_interval_request, watchdog0_interval_request,
                transfer_sw_done_request, flag_q & pin_request_enable_reg,
                nmi_pend_q};
  // Break and non-maskable sit in no group; they go with the high level
  assign hi_lvl = {{`ISVL_NFRT{priority_level_regs[7]}}, priority_level_regs[6], 1'b1,
                   priority_level_regs[5:0], 1'b1};

  function automatic logic [3:0] first_set(input logic [`ISVL_NSRC-1:0] v);
    logic [3:0] r;
    r = 4'hf;
    for (int k = `ISVL_NSRC - 1; k >= 0; k--) begin
      if (v[k]) r = 4'(k);
    end
    return r;
  endfunction

  // Slot order equals vector order, so lowest slot means lowest vector
  wire [`ISVL_NSRC-1:0] hi_req   = req & hi_lvl;
  wire [3:0]            win      = nmi_pend_q ? 4'(`ISVL_SRC_NMI)
                                 : (|hi_req ? first_set(hi_req) : first_set(req));
  wire                  any_req  = |req;
  isvl_vec_t            win_vec;
  isvl_addr_t           win_addr;

  isvl_vector_map u_map (
    .slot          (win),
    .advanced_mode (advanced_mode),
    .vec_num       (win_vec),
    .vec_addr      (win_addr)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_valid_q       <= 1'b0;
      irq_nonmaskable_q <= 1'b0;
      irq_to_transfer_q <= 1'b0;
      irq_vector_q      <= `ISVL_VEC_NONE;
      irq_address_q     <= '0;
      wake_q            <= 1'b0;
      pin_sense_q       <= '0;
    end else if (clk_en) begin
      irq_valid_q       <= any_req;
      // Mask-free delivery for the non-maskable and transfer-routed requests
      irq_nonmaskable_q <= nmi_pend_q | (any_req & transfer_route);
      irq_to_transfer_q <= any_req & transfer_route & ~nmi_pend_q;
      irq_vector_q      <= any_req ? win_vec : `ISVL_VEC_NONE;
      irq_address_q     <= any_req ? win_addr : '0;
      wake_q            <= software_standby & (nmi_edge | |hit);
      pin_sense_q       <= hit;
    end
  end
  assign pin_request_status_reg = flag_q;

  // ============================================================
  // Checks
  a_nmi_wins: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && nmi_pend_q |=> irq_vector_q == `ISVL_VEC_NMI)
    else $error("nmi not granted");
  a_nmi_edge: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && nmi_edge |=> nmi_pend_q)
    else $error("nmi edge lost");
  a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && hit[0] |=> flag_q[0])
    else $error("flag not set on hit");
  a_write_one: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && flag_q[0] && status_wr && status_wdata[0] && !pin_ack |=> flag_q[0])
    else $error("write one cleared flag");
  a_no_read_clr: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && flag_q[1] && !read_one_q[1] && !pin_ack |=> flag_q[1])
    else $error("flag cleared without read");
  a_addr_scale: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && !advanced_mode |=> irq_address_q == {16'h0000, irq_vector_q, 1'h0})
    else $error("normal address wrong");
  a_no_reserved: assert property (@(posedge sys_clk) disable iff (rst)
    irq_valid_q |-> !(irq_vector_q inside {[7'd19:7'd23], [7'd29:7'd47], [7'd55:7'd63]}))
    else $error("reserved vector raised");
  a_default_order: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && priority_level_regs == 8'h00 && !nmi_pend_q && req[1] |=> irq_vector_q == 7'd16)
    else $error("default order broken");
  c_nmi: cover property (@(posedge sys_clk) disable iff (rst) nmi_edge ##[1:3] irq_valid_q);
  c_clear: cover property (@(posedge sys_clk) disable iff (rst) status_rd ##1 status_wr);
  c_frt: cover property (@(posedge sys_clk) disable iff (rst) irq_vector_q == 7'd54);
endmodule

/* File: testbench/isvl_core_model.sv */
`timescale 1ns/1ps
module isvl_core_model import isvl_pkg::*; (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Behaviour
  input  wire logic       ack_en,
  input  wire logic       slow,
  // Requests
  input  wire logic       irq_valid_q,
  input  wire logic       irq_nonmaskable_q,
  input  wire isvl_vec_t  irq_vector_q,
  // Acknowledges
  output logic            nmi_ack,
  output logic            pin_ack,
  output logic [1:0]      pin_ack_index
);
  // ============================================================
  // Acceptance delay
  // Delay of at least four keeps a stale request from being taken twice
  logic [3:0] wait_q;
  wire  [3:0] lim = slow ? 4'ha : 4'h4;
  wire        go  = ack_en && irq_valid_q && (wait_q == lim);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_q        <= 4'h0;
      nmi_ack       <= 1'b0;
      pin_ack       <= 1'b0;
      pin_ack_index <= 2'h0;
    end else begin
      wait_q  <= (ack_en && irq_valid_q && !go) ? wait_q + 4'h1 : 4'h0;
      // Mask state plays no part for the non-maskable request
      nmi_ack <= go && irq_nonmaskable_q;
      pin_ack <= go && !irq_nonmaskable_q && irq_vector_q[6:2] == 5'h04;
      pin_ack_index <= irq_vector_q[1:0];
    end
  end
endmodule

/* File: testbench/isvl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, a); end end
module isvl_tb_top import isvl_pkg::*;;
  // ============================================================
  // Signals
  logic       sys_clk = 1'b0, rst = 1'b1, nmi_pin = 1'b1, edge_sel = 1'b0;
  logic       adv = 1'b0, stby = 1'b0, sense_wr = 1'b0, route = 1'b0;
  logic       status_rd = 1'b0, status_wr = 1'b0, ack_en = 1'b0, slow = 1'b0;
  logic [2:0] pins = 3'h7, pen = 3'h0, wdata = 3'h0, flag, hit;
  logic [5:0] sense = 6'h00;
  logic [7:0] plr = 8'h00;
  logic [11:0] periph = 12'h000;
  logic       nmi_ack, pin_ack, valid, nmiq, xfer, wake;
  logic [1:0] ack_idx;
  isvl_vec_t  vec;
  isvl_addr_t addr;
  int         n_errors = 0, checked = 0, cycles = 0, seed = 32'hbd38, k;
  logic       e;
  always #5 sys_clk = ~sys_clk;
  isvl_top dut_u (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .nmi_pin(nmi_pin),
    .external_request_pins(pins), .nonmaskable_edge_select(edge_sel),
    .advanced_mode(adv), .software_standby(stby), .pin_sense_control_regs(sense),
    .sense_wr(sense_wr), .pin_request_enable_reg(pen), .status_rd(status_rd),
    .status_wr(status_wr), .status_wdata(wdata), .priority_level_regs(plr),
    .transfer_sw_done_request(periph[0]), .watchdog0_interval_request(periph[1]),
    .watchdog1_interval_request(periph[2]), .address_break_request(periph[3]),
    .conversion_done_request(periph[4]), .freerun_timer_requests(periph[11:5]),
    .transfer_route(route), .nmi_ack(nmi_ack), .pin_ack(pin_ack),
    .pin_ack_index(ack_idx), .pin_request_status_reg(flag), .pin_sense_q(hit),
    .irq_valid_q(valid), .irq_nonmaskable_q(nmiq), .irq_to_transfer_q(xfer),
    .irq_vector_q(vec), .irq_address_q(addr), .wake_q(wake));
  isvl_core_model core_u (.sys_clk(sys_clk), .rst(rst), .ack_en(ack_en), .slow(slow),
    .irq_valid_q(valid), .irq_nonmaskable_q(nmiq), .irq_vector_q(vec),
    .nmi_ack(nmi_ack), .pin_ack(pin_ack), .pin_ack_index(ack_idx));
  // ============================================================
  // Expectations
  function automatic isvl_vec_t exp_vec(input logic [11:0] r, input logic [7:0] pl);
    logic [11:0] hi;
    exp_vec = 7'h00;
    hi = r & {{7{pl[7]}}, pl[6], 1'b1, pl[5], pl[4], pl[3]};
    if (hi == 12'h000) hi = r;
    for (int i = 11; i >= 0; i--) if (hi[i]) exp_vec = (i < 5) ? 7'h18 + i : 7'h2b + i;
  endfunction
  function automatic isvl_addr_t exp_addr(input isvl_vec_t v, input logic a);
    exp_addr = a ? {15'h0000, v, 2'h0} : {16'h0000, v, 1'h0};
  endfunction
  // ============================================================
  // Helpers and closing
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] d);
    wdata = d;
    status_wr = 1'b1;
    tick(1);
    status_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd();
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ============================================================
  // Scenarios
  initial begin
    tick(3);
    rst = 1'b0;
    tick(2);
    `CHK("idle vector", 7'h00, vec)
    for (int i = 0; i < 24; i++) begin
      adv = i[0];
      periph = 12'h001 << (i / 2);
      tick(2);
      `CHK("single vector", exp_vec(periph, plr), vec)
      `CHK("single address", exp_addr(exp_vec(periph, plr), adv), addr)
    end
    $display("Test peripheral vectors done");
    for (int i = 0; i < 60; i++) begin
      periph = $random(seed);
      plr = $random(seed);
      {route, adv} = $random(seed);
      tick(2);
      `CHK("pick vector", exp_vec(periph, plr), vec)
      `CHK("pick address", exp_addr(exp_vec(periph, plr), adv), addr)
      `CHK("to transfer", route && periph != 12'h000, xfer)
      `CHK("request valid", periph != 12'h000, valid)
    end
    $display("Test random priority done");
    route = 1'b0;
    for (int m = 0; m < 2; m++) begin
      ack_en = 1'b1;
      edge_sel = m[0];
      nmi_pin = !m[0];
      stby = 1'b1;
      adv = m[0];
      tick(8);
      `CHK("nmi wrong edge", 1'b0, nmiq)
      nmi_pin = m[0];
      e = 1'b0;
      for (k = 0; k < 12 && nmiq !== 1'b1; k++) begin
        tick(1);
        e = e | wake;
      end
      `CHK("nmi vector", 7'h07, vec)
      `CHK("nmi address", m[0] ? 24'h00001c : 24'h00000e, addr)
      `CHK("wake", 1'b1, e | wake)
      for (k = 0; k < 20 && nmiq !== 1'b0; k++) tick(1);
      `CHK("nmi taken", 1'b0, nmiq)
      stby = 1'b0;
    end
    $display("Test non-maskable done");
    ack_en = 1'b0;
    periph = 12'h000;
    plr = 8'h00;
    for (int i = 0; i < 12; i++) begin
      sense[2*(i/4) +: 2] = i % 4;
      sense_wr = 1'b1;
      pen = $random(seed);
      tick(1);
      sense_wr = 1'b0;
      // Pins are driven as plain inputs only, never shared with another use
      pins[i/4] = 1'b0;
      tick(8);
      `CHK("sense hit", (i % 4) == 0, hit[i/4])
      e = (i % 4) != 2;
      `CHK("flag after fall", e, flag[i/4])
      `CHK("pin vector", (e && pen[i/4]) ? 7'h10 + i/4 : 7'h00, vec)
      pins[i/4] = 1'b1;
      tick(8);
      e = e | ((i % 4) >= 2);
      `CHK("flag after rise", e, flag[i/4])
      wr(3'h0);
      `CHK("clear without read", e, flag[i/4])
      rd();
      wr(3'h7);
      `CHK("write one", e, flag[i/4])
      rd();
      wr(~(3'h1 << (i / 4)));
      tick(1);
      `CHK("flag cleared", 1'b0, flag[i/4])
    end
    $display("Test pin sense done");
    ack_en = 1'b1;
    slow = 1'b1;
    pen = 3'h2;
    pins[1] = 1'b0;
    for (k = 0; k < 12 && flag[1] !== 1'b1; k++) tick(1);
    for (k = 0; k < 30 && flag[1] !== 1'b0; k++) tick(1);
    `CHK("pin handled", 1'b0, flag[1])
    pins[1] = 1'b1;
    $display("Test pin handling done");
    give_verdict();
  end
endmodule
